// File: transfer_decode_pkg.sv
// Constants and types shared by the data transfer decoder and its helpers.
// Assumes 16-bit instruction words and sixteen 32-bit general registers.
package transfer_decode_pkg;

   // Operand size codes, also the log2 of the byte count
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;

   // Instruction field positions
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 12;
   localparam int FN_HI = 11;
   localparam int FN_LO = 8;
   localparam int FM_HI = 7;
   localparam int FM_LO = 4;
   localparam int LOW_HI = 3;
   localparam int LOW_LO = 0;

   // Top nibble of each transfer group
   localparam logic [3:0] OPC_IDX_STORE = 4'h0;
   localparam logic [3:0] OPC_DISP_STL = 4'h1;
   localparam logic [3:0] OPC_IND_STORE = 4'h2;
   localparam logic [3:0] OPC_DISP_LDL = 4'h5;
   localparam logic [3:0] OPC_IND_LOAD = 4'h6;
   localparam logic [3:0] OPC_DISP_R0 = 4'h8;
   localparam logic [3:0] OPC_CTR_WORD = 4'h9;
   localparam logic [3:0] OPC_CTR_LONG = 4'hD;
   localparam logic [3:0] OPC_IMM = 4'hE;

   // Second nibble of the register-zero displacement group
   localparam logic [3:0] SUB_STB = 4'h0;
   localparam logic [3:0] SUB_STW = 4'h1;
   localparam logic [3:0] SUB_LDB = 4'h4;
   localparam logic [3:0] SUB_LDW = 4'h5;

   // Low nibble codes
   localparam logic [1:0] LOW_PLAIN = 2'h0;
   localparam logic [1:0] LOW_STEP = 2'h1;
   localparam logic [3:0] LOW_MOVE = 4'h3;
   localparam logic [3:0] LOW_IDX_B = 4'h4;
   localparam logic [3:0] LOW_IDX_W = 4'h5;

   localparam logic [3:0] REG_ZERO = 4'h0;
   localparam int DISP_W = 10;

   // Reset values
   localparam logic [31:0] IMM_RESET = 32'h0000_0000;
   localparam logic [9:0] DISP_RESET = 10'h000;

   // Addressing modes presented to execute
   typedef enum logic [3:0] {
      AM_NONE,
      AM_IMM,
      AM_PCREL,
      AM_REG,
      AM_IND,
      AM_PREDEC,
      AM_POSTINC,
      AM_DISP,
      AM_IDX
   } addr_mode_e;

   // Issue sequencing
   typedef enum logic [0:0] {
      ST_ISSUE,
      ST_STRETCH
   } stage_e;

   // Whole state of the decoder
   typedef struct packed {
      stage_e state;
      logic valid;
      logic hit;
      logic [1:0] size;
      addr_mode_e mode;
      logic [3:0] src;
      logic [3:0] dst;
      logic [9:0] disp;
      logic [31:0] imm;
      logic load;
      logic store;
      logic sext;
      logic wreg;
      logic upd_en;
      logic upd_dec;
      logic [2:0] upd_amt;
      logic tflag_we;
   } dec_state_s;

endpackage

// File: transfer_field_decode.sv
// Pure decode of one 16-bit word into transfer class, size and register fields.
// Assumes the word is stable for the cycle in which it is sampled.
`timescale 1ns/100ps
`default_nettype none
module transfer_field_decode
(
   input wire logic [15:0] instr,
   output logic hit,
   output logic [1:0] size,
   output transfer_decode_pkg::addr_mode_e mode,
   output logic [3:0] src,
   output logic [3:0] dst,
   output logic [7:0] disp8,
   output logic load,
   output logic store
);
   logic [3:0] opc;
   logic [3:0] sub;
   logic [3:0] low;

   // Field split
   assign opc = instr[transfer_decode_pkg::OPC_HI:transfer_decode_pkg::OPC_LO];
   assign sub = instr[transfer_decode_pkg::FN_HI:transfer_decode_pkg::FN_LO];
   assign low = instr[transfer_decode_pkg::LOW_HI:transfer_decode_pkg::LOW_LO];

   // Class decode
   always_comb
   begin
      hit = 1'b1;
      size = transfer_decode_pkg::SIZE_LONG;
      mode = transfer_decode_pkg::AM_NONE;
      src = instr[transfer_decode_pkg::FM_HI:transfer_decode_pkg::FM_LO];
      dst = sub;
      disp8 = {4'h0, low};
      load = 1'b0;
      store = 1'b0;
      case (opc)
         transfer_decode_pkg::OPC_IMM:
         begin
            mode = transfer_decode_pkg::AM_IMM;
            disp8 = 8'h00;
         end
         transfer_decode_pkg::OPC_CTR_WORD, transfer_decode_pkg::OPC_CTR_LONG:
         begin
            mode = transfer_decode_pkg::AM_PCREL;
            size = (opc == transfer_decode_pkg::OPC_CTR_WORD) ? transfer_decode_pkg::SIZE_WORD
                                                              : transfer_decode_pkg::SIZE_LONG;
            disp8 = instr[7:0];
            load = 1'b1;
         end
         transfer_decode_pkg::OPC_IND_STORE, transfer_decode_pkg::OPC_IND_LOAD:
         begin
            size = low[1:0];
            store = (opc == transfer_decode_pkg::OPC_IND_STORE);
            load = ~store;
            disp8 = 8'h00;
            if (!store && low == transfer_decode_pkg::LOW_MOVE)
            begin
               mode = transfer_decode_pkg::AM_REG;
               size = transfer_decode_pkg::SIZE_LONG;
               load = 1'b0;
            end
            else if (low[3] || low[1:0] == 2'h3)
               hit = 1'b0;
            else if (low[3:2] == transfer_decode_pkg::LOW_PLAIN)
               mode = transfer_decode_pkg::AM_IND;
            else if (low[3:2] == transfer_decode_pkg::LOW_STEP)
               mode = store ? transfer_decode_pkg::AM_PREDEC
                            : transfer_decode_pkg::AM_POSTINC;
            else
               hit = 1'b0;
         end
         transfer_decode_pkg::OPC_DISP_STL, transfer_decode_pkg::OPC_DISP_LDL:
         begin
            mode = transfer_decode_pkg::AM_DISP;
            store = (opc == transfer_decode_pkg::OPC_DISP_STL);
            load = ~store;
         end
         transfer_decode_pkg::OPC_DISP_R0:
         begin
            mode = transfer_decode_pkg::AM_DISP;
            size = {1'b0, sub[0]};
            case (sub)
               transfer_decode_pkg::SUB_STB, transfer_decode_pkg::SUB_STW:
               begin
                  store = 1'b1;
                  src = transfer_decode_pkg::REG_ZERO;
                  dst = instr[transfer_decode_pkg::FM_HI:transfer_decode_pkg::FM_LO];
               end
               transfer_decode_pkg::SUB_LDB, transfer_decode_pkg::SUB_LDW:
               begin
                  load = 1'b1;
                  dst = transfer_decode_pkg::REG_ZERO;
               end
               default:
                  hit = 1'b0;
            endcase
         end
         transfer_decode_pkg::OPC_IDX_STORE:
         begin
            disp8 = 8'h00;
            if (low == transfer_decode_pkg::LOW_IDX_B || low == transfer_decode_pkg::LOW_IDX_W)
            begin
               mode = transfer_decode_pkg::AM_IDX;
               size = {1'b0, low[0]};
               store = 1'b1;
            end
            else
               hit = 1'b0;
         end
         default:
            hit = 1'b0;
      endcase
      if (!hit)
      begin
         mode = transfer_decode_pkg::AM_NONE;
         load = 1'b0;
         store = 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: transfer_operand_scale.sv
// Displacement scaling, literal extension and register step amount.
// Assumes size codes are byte, word or longword only.
`timescale 1ns/100ps
`default_nettype none
module transfer_operand_scale
(
   input wire logic [1:0] size,
   input wire logic [7:0] disp8,
   input wire logic [7:0] imm8,
   output logic [9:0] disp_scaled,
   output logic [31:0] imm32,
   output logic [2:0] step
);
   logic [9:0] unit;

   // Shift left by the size code
   function automatic logic [9:0] scale_by_size(input logic [9:0] v, input logic [1:0] code);
      logic [9:0] r;
      r = v;
      if (code == transfer_decode_pkg::SIZE_WORD)
         r = {v[8:0], 1'b0};
      else if (code == transfer_decode_pkg::SIZE_LONG)
         r = {v[7:0], 2'b00};
      return r;
   endfunction

   // Scaled operands
   always_comb
   begin
      disp_scaled = scale_by_size({2'b00, disp8}, size);
      unit = scale_by_size(10'h001, size);
      step = unit[2:0];
      imm32 = {{24{imm8[7]}}, imm8};
   end
endmodule
`default_nettype wire

// File: data_transfer_decoder.sv
// Decode stage for 16-bit data transfer instructions with load-use and bus stalls.
// Assumes fetch presents words with valid/ready and execute consumes one per cycle.
//
// Behaviour
// - Register indices come from the four-bit fields, binary 0 to 15.
// - Each transfer issues in one cycle when nothing stalls.
// - Fetch and data access contending for the bus stretches the instruction.
// - Next instruction reading a just-loaded register gets a bubble.
// - Transfers never write the compare flag of the status word.
// - Displacement scaled by one, two or four per operand size.
// - Immediate move sign-extends the 8-bit literal to 32 bits.
// - Counter-relative loads use 8-bit displacement, word and longword forms.
// - Register move copies the whole source register, no memory access.
// - Indirect stores write source to address in destination, three sizes.
// - Indirect loads sign-extend byte and word, longword unchanged.
// - Pre-decrement stores reduce destination by 1, 2 or 4 first.
// - Post-increment loads add 1, 2 or 4 to source afterwards.
// - Displacement stores: byte/word from register zero, longword any source.
// - Displacement loads: byte/word into register zero, longword any destination.
// - Indexed stores address register zero plus destination, byte and word.
`timescale 1ns/100ps
`default_nettype none
module data_transfer_decoder
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic INSTR_VALID,
   input wire logic [15:0] INSTR,
   output logic INSTR_READY,
   input wire logic FETCH_BUS_REQ,
   output logic DEC_VALID,
   output logic DEC_HIT,
   output logic DEC_STRETCH,
   output logic [1:0] OP_SIZE,
   output logic [3:0] ADDR_MODE,
   output logic [3:0] SRC_IDX,
   output logic [3:0] DST_IDX,
   output logic [9:0] DISP_SCALED,
   output logic [31:0] IMM_VALUE,
   output logic IS_LOAD,
   output logic IS_STORE,
   output logic SIGN_EXTEND,
   output logic REG_WRITE,
   output logic UPD_EN,
   output logic UPD_DEC,
   output logic [2:0] UPD_AMOUNT,
   output logic TFLAG_WRITE
);
   transfer_decode_pkg::dec_state_s st_r;
   transfer_decode_pkg::dec_state_s st_nxt;

   logic f_hit;
   logic [1:0] f_size;
   transfer_decode_pkg::addr_mode_e f_mode;
   logic [3:0] f_src;
   logic [3:0] f_dst;
   logic [7:0] f_disp8;
   logic f_load;
   logic f_store;
   logic [9:0] f_disp;
   logic [31:0] f_imm;
   logic [2:0] f_step;
   logic contend;
   logic load_use;
   logic rd_a_en;
   logic rd_b_en;
   logic rd_r0;

   // True when a read port names the register being loaded
   function automatic logic reads_reg(input logic en, input logic [3:0] idx,
      input logic [3:0] loaded);
      return en && (idx == loaded);
   endfunction

   transfer_field_decode u_fields
   (
      .instr(INSTR),
      .hit(f_hit),
      .size(f_size),
      .mode(f_mode),
      .src(f_src),
      .dst(f_dst),
      .disp8(f_disp8),
      .load(f_load),
      .store(f_store)
   );

   transfer_operand_scale u_scale
   (
      .size(f_size),
      .disp8(f_disp8),
      .imm8(INSTR[7:0]),
      .disp_scaled(f_disp),
      .imm32(f_imm),
      .step(f_step)
   );

   // Registers the incoming word reads; unknown words read both fields
   always_comb
   begin
      rd_a_en = 1'b1;
      rd_b_en = 1'b1;
      rd_r0 = 1'b0;
      if (f_hit)
      begin
         rd_a_en = (f_mode != transfer_decode_pkg::AM_IMM)
            && (f_mode != transfer_decode_pkg::AM_PCREL);
         rd_b_en = f_store;
         rd_r0 = (f_mode == transfer_decode_pkg::AM_IDX);
      end
   end

   // Stall causes
   assign contend = st_r.valid && (st_r.load || st_r.store) && FETCH_BUS_REQ
                    && (st_r.state == transfer_decode_pkg::ST_ISSUE);
   assign load_use = st_r.valid && st_r.load && INSTR_VALID
                     && (reads_reg(rd_a_en, f_hit ? f_src : INSTR[7:4], st_r.dst)
                         || reads_reg(rd_b_en, f_hit ? f_dst : INSTR[11:8], st_r.dst)
                         || reads_reg(rd_r0, transfer_decode_pkg::REG_ZERO, st_r.dst));
   assign INSTR_READY = CE && !contend && !load_use;

   // Next state
   always_comb
   begin
      st_nxt = st_r;
      if (CE)
      begin
         case (st_r.state)
            transfer_decode_pkg::ST_ISSUE:
               st_nxt.state = contend ? transfer_decode_pkg::ST_STRETCH
                  : transfer_decode_pkg::ST_ISSUE;
            transfer_decode_pkg::ST_STRETCH:
               st_nxt.state = transfer_decode_pkg::ST_ISSUE;
            default:
               st_nxt.state = transfer_decode_pkg::ST_ISSUE;
         endcase
         if (!contend)
         begin
            st_nxt.valid = INSTR_VALID && !load_use;
            if (INSTR_VALID && !load_use)
            begin
               st_nxt.hit = f_hit;
               st_nxt.size = f_size;
               st_nxt.mode = f_mode;
               st_nxt.src = f_src;
               st_nxt.dst = f_dst;
               st_nxt.disp = f_disp;
               st_nxt.imm = (f_mode == transfer_decode_pkg::AM_IMM) ? f_imm
                  : transfer_decode_pkg::IMM_RESET;
               st_nxt.load = f_load;
               st_nxt.store = f_store;
               st_nxt.sext = f_load && (f_size != transfer_decode_pkg::SIZE_LONG);
               st_nxt.wreg = f_load || f_mode == transfer_decode_pkg::AM_IMM
                             || f_mode == transfer_decode_pkg::AM_REG;
               st_nxt.upd_en = (f_mode == transfer_decode_pkg::AM_PREDEC)
                               || (f_mode == transfer_decode_pkg::AM_POSTINC);
               st_nxt.upd_dec = (f_mode == transfer_decode_pkg::AM_PREDEC);
               st_nxt.upd_amt = st_nxt.upd_en ? f_step : 3'h0;
               st_nxt.tflag_we = 1'b0;
            end
         end
      end
   end

   // State register
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_r <= '{state: transfer_decode_pkg::ST_ISSUE, mode: transfer_decode_pkg::AM_NONE,
                   disp: transfer_decode_pkg::DISP_RESET, imm: transfer_decode_pkg::IMM_RESET,
                   default: '0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign DEC_VALID = st_r.valid;
   assign DEC_HIT = st_r.hit;
   assign DEC_STRETCH = (st_r.state == transfer_decode_pkg::ST_STRETCH);
   assign OP_SIZE = st_r.size;
   assign ADDR_MODE = st_r.mode;
   assign SRC_IDX = st_r.src;
   assign DST_IDX = st_r.dst;
   assign DISP_SCALED = st_r.disp;
   assign IMM_VALUE = st_r.imm;
   assign IS_LOAD = st_r.load;
   assign IS_STORE = st_r.store;
   assign SIGN_EXTEND = st_r.sext;
   assign REG_WRITE = st_r.wreg;
   assign UPD_EN = st_r.upd_en;
   assign UPD_DEC = st_r.upd_dec;
   assign UPD_AMOUNT = st_r.upd_amt;
   assign TFLAG_WRITE = st_r.tflag_we;

   // Checks
   a_field_index: assert property (@(posedge CLK) disable iff (!RST_N)
      (INSTR_READY && INSTR_VALID && INSTR[15:12] == 4'h6 && f_hit)
      |=> (SRC_IDX == $past(INSTR[7:4]))
          && (DST_IDX == $past(INSTR[11:8])))
      else $error("register index fields misdecoded");

   a_one_cycle_issue: assert property (@(posedge CLK) disable iff (!RST_N)
      (INSTR_READY && INSTR_VALID) |=> DEC_VALID && !DEC_STRETCH)
      else $error("accepted word not issued next cycle");

   a_contend_stretch: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && DEC_VALID && (IS_LOAD || IS_STORE) && FETCH_BUS_REQ && !DEC_STRETCH)
      |-> !INSTR_READY ##1 (DEC_VALID && DEC_STRETCH
          && $stable(DST_IDX) && $stable(ADDR_MODE)))
      else $error("bus contention did not stretch");

   a_load_use_bubble: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && DEC_VALID && IS_LOAD && INSTR_VALID && !DEC_STRETCH && !FETCH_BUS_REQ
       && INSTR[15:12] == 4'h6 && INSTR[7:4] == DST_IDX)
      |-> !INSTR_READY ##1 !DEC_VALID)
      else $error("load-use hazard not bubbled");

   a_tflag_kept: assert property (@(posedge CLK) disable iff (!RST_N)
      DEC_VALID |-> !TFLAG_WRITE)
      else $error("transfer wrote the compare flag");

   a_disp_long_scaled: assert property (@(posedge CLK) disable iff (!RST_N)
      (INSTR_READY && INSTR_VALID && INSTR[15:12] == 4'h1)
      |=> DISP_SCALED == {4'h0, $past(INSTR[3:0]), 2'b00})
      else $error("longword displacement not scaled by four");

   a_imm_sign_ext: assert property (@(posedge CLK) disable iff (!RST_N)
      (INSTR_READY && INSTR_VALID && INSTR[15:12] == 4'hE)
      |=> IMM_VALUE == {{24{$past(INSTR[7])}}, $past(INSTR[7:0])}
          && REG_WRITE)
      else $error("immediate not sign-extended");

   a_pcrel_long: assert property (@(posedge CLK) disable iff (!RST_N)
      (INSTR_READY && INSTR_VALID && INSTR[15:12] == 4'hD)
      |=> ADDR_MODE == 4'h2 && OP_SIZE == 2'h2 && IS_LOAD
          && DISP_SCALED == {$past(INSTR[7:0]), 2'b00})
      else $error("counter-relative longword misdecoded");

   a_predec_step: assert property (@(posedge CLK) disable iff (!RST_N)
      (DEC_VALID && ADDR_MODE == 4'h5)
      |-> UPD_EN && UPD_DEC && IS_STORE && UPD_AMOUNT == (3'h1 << OP_SIZE))
      else $error("pre-decrement step wrong");

   a_postinc_step: assert property (@(posedge CLK) disable iff (!RST_N)
      (DEC_VALID && ADDR_MODE == 4'h6)
      |-> UPD_EN && !UPD_DEC && IS_LOAD && UPD_AMOUNT == (3'h1 << OP_SIZE)
          && SIGN_EXTEND == (OP_SIZE != 2'h2))
      else $error("post-increment step wrong");

   a_move_no_mem: assert property (@(posedge CLK) disable iff (!RST_N)
      (DEC_VALID && ADDR_MODE == 4'h3)
      |-> !IS_LOAD && !IS_STORE && REG_WRITE && OP_SIZE == 2'h2)
      else $error("register move wrong");

   a_ind_store: assert property (@(posedge CLK) disable iff (!RST_N)
      (INSTR_READY && INSTR_VALID && INSTR[15:12] == 4'h2 && INSTR[3:2] == 2'h0 && INSTR[1:0] != 2'h3)
      |=> IS_STORE && ADDR_MODE == 4'h4 && OP_SIZE == $past(INSTR[1:0])
          && SRC_IDX == $past(INSTR[7:4]) && DST_IDX == $past(INSTR[11:8]))
      else $error("indirect store wrong");

   a_load_extend: assert property (@(posedge CLK) disable iff (!RST_N)
      (DEC_VALID && IS_LOAD)
      |-> REG_WRITE && SIGN_EXTEND == (OP_SIZE != 2'h2))
      else $error("load extension wrong");

   a_zero_store: assert property (@(posedge CLK) disable iff (!RST_N)
      (INSTR_READY && INSTR_VALID && INSTR[15:9] == 7'h40)
      |=> IS_STORE && SRC_IDX == 4'h0 && DST_IDX == $past(INSTR[7:4])
          && DISP_SCALED == ({6'h00, $past(INSTR[3:0])} << $past(INSTR[8])))
      else $error("zero-register store wrong");

   a_zero_load: assert property (@(posedge CLK) disable iff (!RST_N)
      (INSTR_READY && INSTR_VALID && INSTR[15:9] == 7'h42)
      |=> IS_LOAD && SIGN_EXTEND && DST_IDX == 4'h0 && SRC_IDX == $past(INSTR[7:4]))
      else $error("zero-register load wrong");

   a_idx_store: assert property (@(posedge CLK) disable iff (!RST_N)
      (DEC_VALID && ADDR_MODE == 4'h8)
      |-> IS_STORE && !UPD_EN && OP_SIZE != 2'h2 && DISP_SCALED == 10'h000)
      else $error("indexed store wrong");

   a_stretch_once: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && DEC_STRETCH)
      |=> !DEC_STRETCH)
      else $error("stretch too long");

   a_miss_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
      (DEC_VALID && !DEC_HIT)
      |-> ADDR_MODE == 4'h0 && !IS_LOAD && !IS_STORE && !REG_WRITE && !UPD_EN)
      else $error("unknown word has effects");

   a_step_idle: assert property (@(posedge CLK) disable iff (!RST_N)
      (DEC_VALID && !UPD_EN)
      |-> UPD_AMOUNT == 3'h0 && !UPD_DEC)
      else $error("step without update");
endmodule
`default_nettype wire

// File: fetch_source.sv
// Fetch-stage model that offers 16-bit instruction words to the decoder.
// Assumes the bench calls its tasks a small fixed delay after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module fetch_source
(
   input wire logic clk,
   input wire logic instr_ready,
   output logic instr_valid,
   output logic [15:0] instr
);
   logic [15:0] last_word;

   // Idle lines at time zero
   initial
   begin
      instr_valid = 1'b0;
      instr = 16'hFFFF;
      last_word = 16'h0000;
   end

   // Holds the word until the decoder takes it and counts the edges spent
   task automatic offer(input logic [15:0] w, output int cycles);
      logic rdy;
      begin
         instr_valid = 1'b1;
         instr = w;
         last_word = w;
         cycles = 0;
         do
         begin
            @(negedge clk);
            rdy = instr_ready;
            @(posedge clk);
            cycles++;
         end
         while (rdy !== 1'b1 && cycles < 50);
         #2;
      end
   endtask

   // Drops the request; the word lines no longer show the old value
   task automatic release_word();
      instr_valid = 1'b0;
      instr = ~last_word;
   endtask
endmodule
`default_nettype wire

// File: data_transfer_decoder_tb_top.sv
// Self-checking bench for the data transfer decoder.
// Assumes the fetch model drives the word inputs and the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module data_transfer_decoder_tb_top;
   logic clk, rst_n, ce, fetch_req, instr_valid, instr_ready;
   logic [15:0] instr;
   logic dec_valid, dec_hit, dec_stretch, is_load, is_store, sign_extend, reg_write;
   logic upd_en, upd_dec, tflag_write;
   logic [1:0] op_size;
   logic [3:0] addr_mode, src_idx, dst_idx;
   logic [9:0] disp_scaled;
   logic [31:0] imm_value;
   logic [2:0] upd_amount;
   int bad_count = 0;
   int check_count = 0;
   int stretch_seen = 0;
   int bubble_seen = 0;
   int n;

   data_transfer_decoder data_transfer_decoder_i (.CLK(clk), .RST_N(rst_n), .CE(ce), .INSTR_VALID(instr_valid),
      .INSTR(instr), .INSTR_READY(instr_ready), .FETCH_BUS_REQ(fetch_req), .DEC_VALID(dec_valid),
      .DEC_HIT(dec_hit), .DEC_STRETCH(dec_stretch), .OP_SIZE(op_size), .ADDR_MODE(addr_mode),
      .SRC_IDX(src_idx), .DST_IDX(dst_idx), .DISP_SCALED(disp_scaled), .IMM_VALUE(imm_value),
      .IS_LOAD(is_load), .IS_STORE(is_store), .SIGN_EXTEND(sign_extend), .REG_WRITE(reg_write),
      .UPD_EN(upd_en), .UPD_DEC(upd_dec), .UPD_AMOUNT(upd_amount), .TFLAG_WRITE(tflag_write));

   fetch_source fetch_source_i (.clk(clk), .instr_ready(instr_ready), .instr_valid(instr_valid), .instr(instr));

   // Clock at 25 MHz
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Counts stretched and empty cycles mid-cycle, clear of edge updates
   always @(negedge clk)
   begin
      if (dec_stretch === 1'b1)
         stretch_seen++;
      if (dec_valid === 1'b0)
         bubble_seen++;
   end

   // Counts one comparison and reports a mismatch
   task automatic expect_true(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask

   // Prints the counts and the verdict, then stops
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Issues one word alone and compares every decoded field
   task automatic dc(input logic [15:0] w, input logic [3:0] md, input logic [1:0] osz, input logic [3:0] s,
      input logic [3:0] d, input logic [9:0] dp, input logic [5:0] fl, input logic [2:0] amt);
      logic [31:0] imm_x;
      logic size_ok, sd_ok;
      begin
         fetch_source_i.offer(w, n);
         fetch_source_i.release_word();
         imm_x = (md == 4'h1) ? {{24{w[7]}}, w[7:0]} : 32'h0000_0000;
         size_ok = (md inside {4'h1, 4'h3}) || (op_size === osz);
         sd_ok = (md == 4'h1 || md == 4'h2 || src_idx === s) && (dst_idx === d);
         expect_true(n == 1 && dec_valid === 1'b1 && dec_hit === (md != 4'h0), $sformatf("issue %h", w));
         expect_true(addr_mode === md && tflag_write === 1'b0, $sformatf("mode %h", w));
         if (md != 4'h0)
            expect_true(size_ok && sd_ok && disp_scaled === dp && imm_value === imm_x && upd_amount === amt
               && {is_load, is_store, sign_extend, reg_write, upd_en, upd_dec} === fl, $sformatf("fields %h", w));
         @(posedge clk);
         #2;
      end
   endtask

   // Every transfer form, with register fields 0xA and 0x5 where free
   task automatic decode_table();
      dc(16'hE3FF, 4'h1, 2'h2, 4'h0, 4'h3, 10'h000, 6'b000100, 3'h0);
      dc(16'hE37F, 4'h1, 2'h2, 4'h0, 4'h3, 10'h000, 6'b000100, 3'h0);
      dc(16'h9A12, 4'h2, 2'h1, 4'h0, 4'hA, 10'h024, 6'b101100, 3'h0);
      dc(16'hDAFF, 4'h2, 2'h2, 4'h0, 4'hA, 10'h3FC, 6'b100100, 3'h0);
      dc(16'h6A53, 4'h3, 2'h2, 4'h5, 4'hA, 10'h000, 6'b000100, 3'h0);
      dc(16'h6F03, 4'h3, 2'h2, 4'h0, 4'hF, 10'h000, 6'b000100, 3'h0);
      dc(16'h60F3, 4'h3, 2'h2, 4'hF, 4'h0, 10'h000, 6'b000100, 3'h0);
      dc(16'h2A50, 4'h4, 2'h0, 4'h5, 4'hA, 10'h000, 6'b010000, 3'h0);
      dc(16'h2A51, 4'h4, 2'h1, 4'h5, 4'hA, 10'h000, 6'b010000, 3'h0);
      dc(16'h2A52, 4'h4, 2'h2, 4'h5, 4'hA, 10'h000, 6'b010000, 3'h0);
      dc(16'h6A50, 4'h4, 2'h0, 4'h5, 4'hA, 10'h000, 6'b101100, 3'h0);
      dc(16'h6A51, 4'h4, 2'h1, 4'h5, 4'hA, 10'h000, 6'b101100, 3'h0);
      dc(16'h6A52, 4'h4, 2'h2, 4'h5, 4'hA, 10'h000, 6'b100100, 3'h0);
      dc(16'h2A54, 4'h5, 2'h0, 4'h5, 4'hA, 10'h000, 6'b010011, 3'h1);
      dc(16'h2A55, 4'h5, 2'h1, 4'h5, 4'hA, 10'h000, 6'b010011, 3'h2);
      dc(16'h2A56, 4'h5, 2'h2, 4'h5, 4'hA, 10'h000, 6'b010011, 3'h4);
      dc(16'h6A54, 4'h6, 2'h0, 4'h5, 4'hA, 10'h000, 6'b101110, 3'h1);
      dc(16'h6A55, 4'h6, 2'h1, 4'h5, 4'hA, 10'h000, 6'b101110, 3'h2);
      dc(16'h6A56, 4'h6, 2'h2, 4'h5, 4'hA, 10'h000, 6'b100110, 3'h4);
      dc(16'h80A7, 4'h7, 2'h0, 4'h0, 4'hA, 10'h007, 6'b010000, 3'h0);
      dc(16'h81A7, 4'h7, 2'h1, 4'h0, 4'hA, 10'h00E, 6'b010000, 3'h0);
      dc(16'h1A5F, 4'h7, 2'h2, 4'h5, 4'hA, 10'h03C, 6'b010000, 3'h0);
      dc(16'h845F, 4'h7, 2'h0, 4'h5, 4'h0, 10'h00F, 6'b101100, 3'h0);
      dc(16'h855F, 4'h7, 2'h1, 4'h5, 4'h0, 10'h01E, 6'b101100, 3'h0);
      dc(16'h5A5F, 4'h7, 2'h2, 4'h5, 4'hA, 10'h03C, 6'b100100, 3'h0);
      dc(16'h0A54, 4'h8, 2'h0, 4'h5, 4'hA, 10'h000, 6'b010000, 3'h0);
      dc(16'h0A55, 4'h8, 2'h1, 4'h5, 4'hA, 10'h000, 6'b010000, 3'h0);
      dc(16'h3A5C, 4'h0, 2'h0, 4'h0, 4'h0, 10'h000, 6'b000000, 3'h0);
   endtask

   // Fetch wants the bus while a load sits in decode: one stretch only
   task automatic bus_contention();
      int s0;
      begin
         fetch_source_i.offer(16'h6A52, n);
         fetch_req = 1'b1;
         s0 = stretch_seen;
         fetch_source_i.offer(16'h6B13, n);
         fetch_source_i.release_word();
         fetch_req = 1'b0;
         expect_true(n == 2 && stretch_seen - s0 == 1, "stretch count");
         expect_true(addr_mode === 4'h3 && dst_idx === 4'hB && dec_stretch === 1'b0, "word after stretch");
         @(posedge clk);
         #2;
      end
   endtask

   // Next word reads the loaded register, then one that does not
   task automatic load_use();
      int b0;
      begin
         fetch_source_i.offer(16'h6012, n);
         b0 = bubble_seen;
         fetch_source_i.offer(16'h6003, n);
         expect_true(n == 2 && bubble_seen - b0 == 1, "load-use bubble");
         expect_true(dec_valid === 1'b1 && addr_mode === 4'h3 && src_idx === 4'h0, "word after bubble");
         fetch_source_i.offer(16'h6A52, n);
         fetch_source_i.offer(16'h6B13, n);
         expect_true(n == 1, "no bubble without shared register");
         fetch_source_i.release_word();
         @(posedge clk);
         #2;
      end
   endtask

   // Clock enable low freezes the decoded word and refuses new ones
   task automatic freeze();
      fetch_source_i.offer(16'hE3FF, n);
      fetch_source_i.release_word();
      ce = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      expect_true(dec_valid === 1'b1 && imm_value === 32'hFFFF_FFFF && instr_ready === 1'b0, "frozen");
      ce = 1'b1;
      @(posedge clk);
      #2;
   endtask

   // Cuts a hang short well past the expected run length
   initial
   begin
      #80000;
      bad_count++;
      $display("wrong value at %0t: run did not finish", $time);
      complete_run();
   end

   // Reset, then the scenarios in turn
   initial
   begin
      rst_n = 1'b0;
      ce = 1'b1;
      fetch_req = 1'b0;
      repeat (3) @(posedge clk);
      #2;
      rst_n = 1'b1;
      decode_table();
      bus_contention();
      load_use();
      freeze();
      complete_run();
   end
endmodule
`default_nettype wire
